// file: rtl/ssr_cfg.svh
// Constants of the safety release and diagnostic block: offsets, bit positions, reset values, timing
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

// ********************************************
// Timing
// ********************************************
`define SSR_CLK_MHZ 100
`define SSR_DISC_MS 500
`define SSR_WARN_MIN 30
`define SSR_BLINK_HZ 5
`define SSR_DEB_MS 10
`define SSR_DISC_CYC (`SSR_DISC_MS * `SSR_CLK_MHZ * 1000)
`define SSR_WARN_CYC (64'd60000 * `SSR_WARN_MIN * `SSR_CLK_MHZ * 1000)
`define SSR_BLINK_HALF_CYC (`SSR_CLK_MHZ * 1000000 / (2 * `SSR_BLINK_HZ))
`define SSR_DEB_CYC (`SSR_DEB_MS * `SSR_CLK_MHZ * 1000)

// ********************************************
// Register offsets (byte addresses)
// ********************************************
`define SSR_OFS_CONFIG 12'h000
`define SSR_OFS_REQUEST 12'h004
`define SSR_OFS_RESPONSE 12'h008
`define SSR_OFS_WARNING 12'h00c
`define SSR_OFS_ERROR 12'h010

// ********************************************
// Field positions
// ********************************************
`define SSR_CFG_MONITORED 0
`define SSR_CFG_DISC_EN 1
`define SSR_REQ_ACK 6
`define SSR_REQ_RESET 7
`define SSR_RSP_ON 0
`define SSR_RSP_ACT 1
`define SSR_RSP_FB_OPEN 3
`define SSR_RSP_INPUTS 4
`define SSR_RSP_HYST 5
`define SSR_RSP_WARN 6
`define SSR_RSP_ERR 7
`define SSR_DG_TEMP 3
`define SSR_DG_ACTUATOR 4
`define SSR_DG_INTERNAL 5
`define SSR_DG_BIT6 6

// ********************************************
// Reset values
// ********************************************
`define SSR_CONFIG_RST 8'h02
`define SSR_REQUEST_RST 8'h00

`endif

// file: rtl/ssr_pkg.sv
// Types shared by the safety release and diagnostic block
package ssr_pkg;

  // Release state of the enabling path
  typedef enum logic [0:0] {
    ssr_st_off = 1'b0,
    ssr_st_on = 1'b1
  } ssr_state_t;

endpackage : ssr_pkg

// file: rtl/ssr_debounce.sv
// Pin synchroniser with stable-level filter
`timescale 1ns/1ps
`default_nettype none

module ssr_debounce #(
  parameter int unsigned CYCLES = 1,
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw pin and filtered level
  input wire logic pin,
  output logic level
);

  localparam int CW = $clog2(CYCLES + 1);

  logic s1;
  logic s2;
  logic [CW-1:0] cnt;

  // Two-stage synchroniser; s1 feeds only s2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
    end else begin
      s1 <= pin;
      s2 <= s1;
    end
  end

  // Level follows only after it stayed put, so bounce gives one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      level <= RST_VAL;
    end else if (s2 == level) begin
      cnt <= '0;
    end else if (cnt == CW'(CYCLES - 1)) begin
      cnt <= '0;
      level <= s2;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  chk_debounce_stable: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(level) |-> level == $past(s2) && cnt == '0)
    else $error("Filtered level changed without a settled input");

endmodule : ssr_debounce

`default_nettype wire

// file: rtl/ssr_core.sv
// Release, latching and diagnostic status logic of the safety sensor
//
// Behaviour
// - Over-temperature sets bit 3 of warning or error byte by severity.
// - Response bit 4 shows both safety inputs energised.
// - Response bit 5 shows actuator only in hysteresis zone.
// - Error bit 4 flags a wrong or faulty actuator.
// - Internal fault sets warning or error bit 5 by shutdown urgency.
// - Warning bit 6 flags failed gateway communication.
// - Error bit 6 flags exceeded discrepancy time between safety inputs.
// - After power-up with feedback open: outputs off, yellow blinks 5 Hz.
// - Auto-release variant enables outputs once feedback closes with actuator present.
// - Monitored-reset variant enables only on reset button falling edge.
// - Enabled outputs switch yellow indicator from blinking to steady.
// - With monitoring on, input shutdowns differing over 500 ms disable outputs.
// - Discrepancy error blocks release until acknowledged.
// - Discrepancy error survives supply loss via nonvolatile storage.
// - Acknowledge button falling edge or serial request clears discrepancy error.
// - Warning held 30 minutes switches outputs off and blinks red.
// - Internal error clears when cause gone and request bit 7 falls, or guard opens.
// - Response bit 0 shows outputs enabled, bit 1 actuator detected.
//
// The APB register port and the register offsets were chosen for this implementation.
`include "ssr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ssr_core #(
  parameter int unsigned DISC_CYC = `SSR_DISC_CYC,
  parameter longint unsigned WARN_CYC = `SSR_WARN_CYC,
  parameter int unsigned BLINK_HALF_CYC = `SSR_BLINK_HALF_CYC,
  parameter int unsigned DEB_CYC = `SSR_DEB_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from the field
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  input wire logic feedback_closed,
  input wire logic reset_button,
  input wire logic ack_button,
  // Conditions from the sensing logic
  input wire logic actuator_present,
  input wire logic actuator_hysteresis,
  input wire logic actuator_faulty,
  input wire logic temp_warning,
  input wire logic temp_error,
  input wire logic int_fault_delayed,
  input wire logic int_fault_immediate,
  input wire logic gateway_comm_fail,
  // Nonvolatile discrepancy store
  input wire logic disc_nv_in,
  output logic disc_error_nv,
  // Enabling path and indicators
  output logic safety_output_a,
  output logic safety_output_b,
  output logic led_yellow,
  output logic led_red,
  output logic led_green
);

  localparam int DW = $clog2(DISC_CYC + 1);
  localparam int WW = $clog2(WARN_CYC + 1);
  localparam int BW = $clog2(BLINK_HALF_CYC + 1);

  // ********************************************
  // Pin conditioning
  // ********************************************
  logic in_a;
  logic in_b;
  logic fb_db;
  logic rb_db;
  logic ack_db;
  logic rb_q;
  logic ack_q;
  logic rb_fall;
  logic ack_fall;

  ssr_debounce #(.CYCLES(1), .RST_VAL(1'b0)) u_in_a (
    .pclk(pclk), .presetn(presetn), .pin(safety_input_a), .level(in_a));
  ssr_debounce #(.CYCLES(1), .RST_VAL(1'b0)) u_in_b (
    .pclk(pclk), .presetn(presetn), .pin(safety_input_b), .level(in_b));
  ssr_debounce #(.CYCLES(1), .RST_VAL(1'b0)) u_fb (
    .pclk(pclk), .presetn(presetn), .pin(feedback_closed), .level(fb_db));
  ssr_debounce #(.CYCLES(DEB_CYC), .RST_VAL(1'b0)) u_rb (
    .pclk(pclk), .presetn(presetn), .pin(reset_button), .level(rb_db));
  ssr_debounce #(.CYCLES(DEB_CYC), .RST_VAL(1'b0)) u_ack (
    .pclk(pclk), .presetn(presetn), .pin(ack_button), .level(ack_db));

  // Falling edges of the filtered buttons
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      rb_q <= rb_db;
      ack_q <= ack_db;
    end
  end
  assign rb_fall = rb_q & ~rb_db;
  assign ack_fall = ack_q & ~ack_db;

  // ********************************************
  // APB registers
  // ********************************************
  logic [7:0] cfg;
  logic [7:0] req;
  logic wr_acc;
  logic req_ack;
  logic req7_fall;
  logic monitored_reset_variant;
  logic auto_release_variant;
  logic mon_en;
  logic [7:0] rsp_byte;
  logic [7:0] warn_byte;
  logic [7:0] err_byte;
  logic [31:0] rd_val;
  logic rd_hit;

  assign wr_acc = psel & penable & pready & pwrite;
  assign monitored_reset_variant = cfg[`SSR_CFG_MONITORED];
  assign auto_release_variant = ~monitored_reset_variant;
  assign mon_en = cfg[`SSR_CFG_DISC_EN];
  // Serial acknowledge is a write with the acknowledge bit set
  assign req_ack = wr_acc & (paddr == `SSR_OFS_REQUEST) & pwdata[`SSR_REQ_ACK];
  assign req7_fall = wr_acc & (paddr == `SSR_OFS_REQUEST) & req[`SSR_REQ_RESET] & ~pwdata[`SSR_REQ_RESET];

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  // Writable registers take effect on the completing edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= `SSR_CONFIG_RST;
      req <= `SSR_REQUEST_RST;
    end else if (wr_acc) begin
      if (paddr == `SSR_OFS_CONFIG) begin
        cfg <= pwdata[7:0];
      end else if (paddr == `SSR_OFS_REQUEST) begin
        req <= pwdata[7:0];
      end
    end
  end

  // Read decode; unmapped addresses answer zero with an error
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr == `SSR_OFS_CONFIG) begin
      rd_val = {24'h00_0000, cfg};
    end else if (paddr == `SSR_OFS_REQUEST) begin
      rd_val = {24'h00_0000, req};
    end else if (paddr == `SSR_OFS_RESPONSE) begin
      rd_val = {24'h00_0000, rsp_byte};
    end else if (paddr == `SSR_OFS_WARNING) begin
      rd_val = {24'h00_0000, warn_byte};
    end else if (paddr == `SSR_OFS_ERROR) begin
      rd_val = {24'h00_0000, err_byte};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Answer is loaded on the edge that raises pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= ~rd_hit;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // ********************************************
  // Fault latching
  // ********************************************
  logic boot;
  logic one_off;
  logic disc_hit;
  logic [DW-1:0] disc_cnt;
  logic int_err;
  logic any_warn;
  logic warn_to;
  logic [WW-1:0] warn_cnt;
  logic err_any;

  assign any_warn = temp_warning | int_fault_delayed | gateway_comm_fail;
  assign one_off = in_a ^ in_b;
  assign disc_hit = mon_en & one_off & (disc_cnt == DW'(DISC_CYC));
  assign err_any = temp_error | actuator_faulty | int_err | disc_error_nv | warn_to;

  // Time how long one input has been off while the other stays on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disc_cnt <= '0;
    end else if (!mon_en || !one_off) begin
      disc_cnt <= '0;
    end else if (disc_cnt != DW'(DISC_CYC)) begin
      disc_cnt <= disc_cnt + 1'b1;
    end
  end

  // Boot marker: the stored error is reloaded once, after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot <= 1'b1;
    end else begin
      boot <= 1'b0;
    end
  end

  // Discrepancy error; a new trip wins over an acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disc_error_nv <= 1'b0;
    end else if (boot) begin
      disc_error_nv <= disc_nv_in;
    end else if (disc_hit) begin
      disc_error_nv <= 1'b1;
    end else if (ack_fall || req_ack) begin
      disc_error_nv <= 1'b0;
    end
  end

  // Internal error needs cause gone plus reset request or guard opened
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_err <= 1'b0;
    end else if (int_fault_immediate) begin
      int_err <= 1'b1;
    end else if (req7_fall || !actuator_present) begin
      int_err <= 1'b0;
    end
  end

  // A warning that lasts too long becomes a shutdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_cnt <= '0;
      warn_to <= 1'b0;
    end else if (!any_warn) begin
      warn_cnt <= '0;
      warn_to <= 1'b0;
    end else if (warn_cnt == WW'(WARN_CYC - 1)) begin
      warn_to <= 1'b1;
    end else begin
      warn_cnt <= warn_cnt + 1'b1;
    end
  end

  // ********************************************
  // Diagnostic bytes
  // ********************************************
  always_comb begin
    rsp_byte = 8'h00;
    rsp_byte[`SSR_RSP_ON] = safety_output_a;
    rsp_byte[`SSR_RSP_ACT] = actuator_present;
    rsp_byte[`SSR_RSP_FB_OPEN] = ~safety_output_a & ~fb_db;
    rsp_byte[`SSR_RSP_INPUTS] = in_a & in_b;
    rsp_byte[`SSR_RSP_HYST] = actuator_hysteresis;
    rsp_byte[`SSR_RSP_WARN] = any_warn;
    rsp_byte[`SSR_RSP_ERR] = err_any;
  end

  always_comb begin
    warn_byte = 8'h00;
    warn_byte[`SSR_DG_TEMP] = temp_warning;
    warn_byte[`SSR_DG_INTERNAL] = int_fault_delayed;
    warn_byte[`SSR_DG_BIT6] = gateway_comm_fail;
  end

  always_comb begin
    err_byte = 8'h00;
    err_byte[`SSR_DG_TEMP] = temp_error;
    err_byte[`SSR_DG_ACTUATOR] = actuator_faulty;
    err_byte[`SSR_DG_INTERNAL] = int_err;
    err_byte[`SSR_DG_BIT6] = disc_error_nv;
  end

  // ********************************************
  // Release state machine
  // ********************************************
  ssr_pkg::ssr_state_t state;
  ssr_pkg::ssr_state_t next_state;
  logic ok_to_run;

  // Any latched error keeps the path off, so release waits for acknowledge
  assign ok_to_run = actuator_present & in_a & in_b & ~err_any;

  always_comb begin
    next_state = state;
    case (state)
      ssr_pkg::ssr_st_off: begin
        if (ok_to_run && auto_release_variant && fb_db) begin
          next_state = ssr_pkg::ssr_st_on;
        end else if (ok_to_run && monitored_reset_variant && rb_fall) begin
          next_state = ssr_pkg::ssr_st_on;
        end
      end
      ssr_pkg::ssr_st_on: begin
        if (!ok_to_run) begin
          next_state = ssr_pkg::ssr_st_off;
        end
      end
      default: begin
        next_state = ssr_pkg::ssr_st_off;
      end
    endcase
  end

  // Both channels switch together from the same flop input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ssr_pkg::ssr_st_off;
      safety_output_a <= 1'b0;
      safety_output_b <= 1'b0;
    end else begin
      state <= next_state;
      safety_output_a <= (next_state == ssr_pkg::ssr_st_on);
      safety_output_b <= (next_state == ssr_pkg::ssr_st_on);
    end
  end

  // ********************************************
  // Indicators
  // ********************************************
  logic [BW-1:0] blink_cnt;
  logic blink;

  // Free-running half-period timer for the flashing indicators
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt <= '0;
      blink <= 1'b0;
    end else if (blink_cnt == BW'(BLINK_HALF_CYC - 1)) begin
      blink_cnt <= '0;
      blink <= ~blink;
    end else begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  // Yellow steady when released, flashing while waiting, dark on error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_yellow <= 1'b0;
      led_red <= 1'b0;
      led_green <= 1'b0;
    end else begin
      if (next_state == ssr_pkg::ssr_st_on) begin
        led_yellow <= 1'b1;
      end else begin
        led_yellow <= blink & ~err_any;
      end
      led_red <= err_any ? blink : any_warn;
      led_green <= (next_state == ssr_pkg::ssr_st_off) & ~err_any & ~any_warn;
    end
  end

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence disc_trip_s;
    mon_en && one_off && disc_cnt == DW'(DISC_CYC) && !boot;
  endsequence

  chk_auto_release: assert property (
    state == ssr_pkg::ssr_st_off && auto_release_variant && fb_db && ok_to_run
    |=> safety_output_a && safety_output_b)
    else $error("Auto variant did not release on closed feedback");

  chk_reset_edge_only: assert property (
    state == ssr_pkg::ssr_st_off && monitored_reset_variant && !rb_fall |=> !safety_output_a)
    else $error("Monitored variant released without button edge");

  chk_yellow_steady: assert property (
    safety_output_a |-> led_yellow)
    else $error("Yellow not steady while released");

  chk_yellow_blink_off: assert property (
    $rose(blink) && next_state == ssr_pkg::ssr_st_off && !err_any |=> led_yellow && !safety_output_a)
    else $error("Yellow not flashing while waiting");

  chk_disc_trip: assert property (
    disc_trip_s |=> disc_error_nv ##1 !safety_output_a && !safety_output_b)
    else $error("Discrepancy did not trip the outputs");

  chk_disc_blocks: assert property (
    disc_error_nv |=> !safety_output_a)
    else $error("Released while discrepancy error stands");

  chk_disc_ack: assert property (
    disc_error_nv && (ack_fall || req_ack) && !disc_hit && !boot |=> !disc_error_nv)
    else $error("Acknowledge did not clear discrepancy error");

  chk_nv_restore: assert property (
    boot |=> disc_error_nv == $past(disc_nv_in))
    else $error("Stored discrepancy error not restored");

  chk_warn_timeout: assert property (
    warn_to && any_warn |=> !safety_output_a)
    else $error("Long warning did not switch outputs off");

  chk_int_clear: assert property (
    int_err && !int_fault_immediate && req7_fall |=> !int_err ##1 !err_byte[`SSR_DG_INTERNAL])
    else $error("Internal error not cleared by reset request");

  chk_resp_bits: assert property (
    ##1 rsp_byte[`SSR_RSP_ON] == $past(next_state == ssr_pkg::ssr_st_on) && rsp_byte[`SSR_RSP_ACT] == actuator_present)
    else $error("Response bits 0 or 1 wrong");

endmodule : ssr_core

`default_nettype wire

// file: dv/ssr_button.sv
// Bouncing push-button of the outside control, used for reset and acknowledge
`timescale 1ns/1ps
`default_nettype none

module ssr_button (
  // Clock of the sensor
  input wire logic pclk,
  // Button contact, high while pressed
  output logic pin
);
  // ********************************************
  // Button action
  // ********************************************
  // Contact rests open, so the pin idles low
  initial pin = 1'b0;

  // Press with bounce on both edges; release makes the falling edge the device acts on
  task automatic press();
    logic [19:0] pat = 20'b10111111111010000000;
    for (int i = 19; i >= 0; i--) begin
      @(posedge pclk);
      pin <= pat[i];
    end
  endtask : press
endmodule : ssr_button

`default_nettype wire

// file: dv/safety_release_and_diag_bits_tb_top.sv
// Self-checking bench of the safety release and diagnostic block
`include "ssr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("FAIL %s expected %h seen %h", nm, ex, got); end end

module safety_release_and_diag_bits_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  logic sa = 1'b1, sb = 1'b1, fb = 1'b0, act = 1'b1, hys = 1'b0, flt = 1'b0;
  logic tw = 1'b0, te = 1'b0, ifd = 1'b0, ifi = 1'b0, gw = 1'b0, nv_in = 1'b0;
  logic outa, outb, ly, lr, lg, nv_out, rbtn, abtn;
  logic [31:0] seed = 32'h923bb32d;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;

  // ********************************************
  // Clock, partner and design
  // ********************************************
  always #5 pclk = ~pclk;

  ssr_button u_rbtn (.pclk(pclk), .pin(rbtn));
  ssr_button u_abtn (.pclk(pclk), .pin(abtn));

  // Short counts keep the run brief; expectations use these same figures
  ssr_core #(.DISC_CYC(20), .WARN_CYC(50), .BLINK_HALF_CYC(4), .DEB_CYC(3)) DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .safety_input_a(sa), .safety_input_b(sb), .feedback_closed(fb), .reset_button(rbtn),
    .ack_button(abtn), .actuator_present(act), .actuator_hysteresis(hys),
    .actuator_faulty(flt), .temp_warning(tw), .temp_error(te), .int_fault_delayed(ifd),
    .int_fault_immediate(ifi), .gateway_comm_fail(gw), .disc_nv_in(nv_in),
    .disc_error_nv(nv_out), .safety_output_a(outa), .safety_output_b(outb),
    .led_yellow(ly), .led_red(lr), .led_green(lg));

  // ********************************************
  // Helpers
  // ********************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Response with feedback open: outputs off, so bit 3 is set and bit 0 clear
  function automatic logic [7:0] exp_rsp(input logic [31:0] s);
    return {1'b0, s[5] | s[7] | s[8], s[3], s[0] & s[1], 1'b1, 1'b0, s[2], 1'b0};
  endfunction : exp_rsp

  function automatic logic [7:0] exp_wrn(input logic [31:0] s);
    return {1'b0, s[8], s[7], 1'b0, s[5], 3'b000};
  endfunction : exp_wrn

  function automatic logic [7:0] exp_err(input logic [31:0] s);
    return {3'b000, s[4], s[6], 3'b000};
  endfunction : exp_err

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard, far above the roughly 1200 cycles the sequence needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic cycles(input int n);
    repeat (n) @(posedge pclk);
  endtask : cycles

  // APB master: request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Look just after each edge; the answer stands until the next edge, which completes the transfer
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Masked read check; upper bits must read zero
  task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] m, input logic [7:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK(nm, {24'h0, ex}, rd & {24'hffffff, m})
    `CHK("pslverr", 1'b0, er)
  endtask : rchk

  // Bounded wait for output a to reach a level, then both outputs are checked
  task automatic wait_out(input logic ex, input int mx);
    int n = 0;
    #1;
    while (outa !== ex && n < mx) begin
      @(posedge pclk);
      #1;
      n++;
    end
    `CHK("safety_output_a", ex, outa)
    `CHK("safety_output_b", ex, outb)
  endtask : wait_out

  // Yellow indicator half period, counted between two toggles
  task automatic blink_half();
    int n = 0;
    logic v;
    @(posedge pclk);
    #1;
    v = ly;
    while (ly === v && n < 20) begin
      @(posedge pclk);
      #1;
      n++;
    end
    v = ly;
    n = 0;
    while (ly === v && n < 20) begin
      @(posedge pclk);
      #1;
      n++;
    end
    `CHK("blink_half", 4, n)
  endtask : blink_half

  // ********************************************
  // Main sequence
  // ********************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    cycles(3);
    #1;
    `CHK("safety_output_a", 1'b0, outa)
    `CHK("led_green", 1'b1, lg)
    `CHK("led_red", 1'b0, lr)
    blink_half();
    rchk("config", `SSR_OFS_CONFIG, 8'hff, `SSR_CONFIG_RST);
    rchk("request", `SSR_OFS_REQUEST, 8'hff, `SSR_REQUEST_RST);
    apb(1'b1, 12'h014, 32'hff);
    `CHK("pslverr_wr", 1'b1, er)
    apb(1'b0, 12'h014, 32'h0);
    `CHK("pslverr_rd", 1'b1, er)
    `CHK("unmapped", 32'h0, rd)
    // Monitoring off so random input mismatches cannot trip a discrepancy
    apb(1'b1, `SSR_OFS_CONFIG, 32'h0);
    rchk("config", `SSR_OFS_CONFIG, 8'hff, 8'h00);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      @(posedge pclk);
      {gw, ifd, te, tw, flt, hys, act, sb, sa} <= seed[8:0];
      cycles(4);
      rchk("response", `SSR_OFS_RESPONSE, 8'h7f, exp_rsp(seed));
      rchk("warning", `SSR_OFS_WARNING, 8'h68, exp_wrn(seed));
      rchk("error", `SSR_OFS_ERROR, 8'h18, exp_err(seed));
    end
    @(posedge pclk);
    {gw, ifd, te, tw, flt, hys, act, sb, sa} <= 9'h007;
    cycles(80);
    // Automatic release on feedback closing
    fb <= 1'b1;
    wait_out(1'b1, 10);
    for (int i = 0; i < 12; i++) begin
      @(posedge pclk);
      #1;
      `CHK("led_yellow", 1'b1, ly)
    end
    rchk("response_on", `SSR_OFS_RESPONSE, 8'h01, 8'h01);
    // Long warning: delayed shutdown, then recovery
    tw <= 1'b1;
    cycles(20);
    wait_out(1'b1, 0);
    `CHK("led_red", 1'b1, lr)
    `CHK("led_green", 1'b0, lg)
    wait_out(1'b0, 80);
    tw <= 1'b0;
    wait_out(1'b1, 10);
    // Internal error latched until bit 7 of the request falls
    ifi <= 1'b1;
    @(posedge pclk);
    ifi <= 1'b0;
    wait_out(1'b0, 10);
    rchk("internal", `SSR_OFS_ERROR, 8'h20, 8'h20);
    apb(1'b1, `SSR_OFS_REQUEST, 32'h80);
    apb(1'b1, `SSR_OFS_REQUEST, 32'h00);
    rchk("internal", `SSR_OFS_ERROR, 8'h20, 8'h00);
    wait_out(1'b1, 10);
    // Monitored reset: feedback alone does nothing, button release does
    act <= 1'b0;
    wait_out(1'b0, 10);
    apb(1'b1, `SSR_OFS_CONFIG, 32'h03);
    act <= 1'b1;
    cycles(20);
    wait_out(1'b0, 0);
    u_rbtn.press();
    wait_out(1'b1, 10);
    // Both inputs off within the window: no discrepancy
    sa <= 1'b0;
    cycles(10);
    sb <= 1'b0;
    wait_out(1'b0, 10);
    cycles(30);
    rchk("disc", `SSR_OFS_ERROR, 8'h40, 8'h00);
    {sa, sb} <= 2'b11;
    cycles(4);
    u_rbtn.press();
    wait_out(1'b1, 10);
    // One input off alone: discrepancy trips and blocks release
    sa <= 1'b0;
    cycles(30);
    rchk("disc", `SSR_OFS_ERROR, 8'h40, 8'h40);
    `CHK("disc_error_nv", 1'b1, nv_out)
    sa <= 1'b1;
    u_rbtn.press();
    wait_out(1'b0, 10);
    // Supply loss: the stored error returns from nonvolatile memory
    presetn <= 1'b0;
    nv_in <= 1'b1;
    cycles(5);
    presetn <= 1'b1;
    cycles(10);
    nv_in <= 1'b0;
    rchk("disc_nv", `SSR_OFS_ERROR, 8'h40, 8'h40);
    wait_out(1'b0, 0);
    u_abtn.press();
    cycles(6);
    rchk("disc_ack", `SSR_OFS_ERROR, 8'h40, 8'h00);
    wait_out(1'b1, 10);
    sa <= 1'b0;
    cycles(30);
    rchk("disc", `SSR_OFS_ERROR, 8'h40, 8'h40);
    sa <= 1'b1;
    apb(1'b1, `SSR_OFS_REQUEST, 32'h40);
    rchk("disc_ack", `SSR_OFS_ERROR, 8'h40, 8'h00);
    `CHK("disc_error_nv", 1'b0, nv_out)
    wait_out(1'b1, 10);
    tally_and_finish();
  end
endmodule : safety_release_and_diag_bits_tb_top

`default_nettype wire
